// [hdl/ctc_pkg.sv]
// Notes on behaviour
// - Three identical independent channels, each counting over a 16-bit range.
// - Data ports at 0x00, 0x04, 0x08 and control word at 0x0c; bytes.
// - One control word port shared by all channels sets each channel's own mode and access register.
// - Counting element is a hidden 16-bit down counter behind latch and holding.
// - Output latch follows the counter until a snapshot freezes it.
// - Count written one byte per write into holding, then moved to counter.
// - Data port read gives latch or status byte; write loads holding register.
// - Control word is write-only; seen only through read-back status.
// - Bit 0 picks binary or four-decade decimal counting.
// - Single-byte access forces the unused count byte to zero.
// - Bits 3:1 pick one of the six counting modes.
// - Bits 5:4 pick snapshot, low only, high only, or low then high.
// - Each channel keeps its own byte-order pointer, untouched by other channels.
// - Bits 7:6 pick channel 0 to 2; 11 means read-back command.
// - A new count is taken at any time without changing the mode.
// - Status capture takes control word, count state and output level.
// - One shared external count clock, muxed with a divided system clock.
// - Each channel has its own gate input and output pin.
// - Snapshot holds until read or reprogrammed; a repeat is ignored.
// - Read-back picks channels by bits 1-3; status read before count.
// - Status: bit 7 output, bit 6 load pending, bits 5:0 control fields.
// - Control word write resets the channel, cancels latches, sets output high, or low in mode 0.
`default_nettype none
package ctc_pkg;
  localparam int NUM_CH = 3;
  localparam int CNT_W  = 16;
  localparam logic [7:0] OFS_CNT [0:2] = '{8'h00, 8'h04, 8'h08};
  localparam logic [7:0] OFS_CW  = 8'h0c;
  localparam logic [7:0] OFS_CLK = 8'h10;
  localparam int RB_SEL_LO   = 1;
  localparam int RB_STATUS_N = 4;
  localparam int RB_COUNT_N  = 5;
  localparam logic [1:0] SC_MULTI_CHANNEL_CAPTURE_COMMAND = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_TWO  = 16'h0002;
  typedef enum logic [1:0] {
    AF_LATCH = 2'h0, AF_LOW = 2'h1, AF_HIGH = 2'h2, AF_BOTH = 2'h3
  } ctc_af_t;
  typedef enum logic [2:0] {
    MD_TC_INT = 3'h0, MD_ONESHOT = 3'h1, MD_RATE = 3'h2,
    MD_SQUARE = 3'h3, MD_SW_STROBE = 3'h4, MD_HW_STROBE = 3'h5
  } ctc_mode_t;
  typedef struct packed {
    ctc_af_t   af;
    ctc_mode_t mode;
    logic      bcd;
  } ctc_cw_t;
endpackage
`default_nettype wire

// [hdl/ctc_top.sv]
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module ctc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Counter pins
  input  wire logic              external_count_clock,
  input  wire logic [2:0]        channel_gate_pin,
  output logic [2:0]             channel_output_pin
);

  // One-hot decode: [2:0] data ports, [3] control word, [4] clock select
  function automatic logic [4:0] ctc_decode(input logic [ADDR_W-1:0] a);
    logic [4:0] d;
    d = 5'h00;
    for (int k = 0; k < ctc_pkg::NUM_CH; k++) begin
      d[k] = (a == ADDR_W'(ctc_pkg::OFS_CNT[k]));
    end
    d[3] = (a == ADDR_W'(ctc_pkg::OFS_CW));
    d[4] = (a == ADDR_W'(ctc_pkg::OFS_CLK));
    return d;
  endfunction

  // Single-step decrement in binary or four decimal decades
  function automatic logic [15:0] ctc_dec1(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r = v - ctc_pkg::CNT_ONE;
    borrow = 1'b1;
    if (bcd) begin
      r = v;
      for (int k = 0; k < 4; k++) begin
        if (borrow) begin
          if (r[4*k +: 4] == 4'h0) begin
            r[4*k +: 4] = ctc_pkg::BCD_NINE;
          end else begin
            r[4*k +: 4] = r[4*k +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // Bus slave
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_byte;
  logic              wr_be;
  logic [15:0]       clk_sel;
  logic [7:0]        rd_byte;

  wire       aw_hs  = awvalid & awready;
  wire       w_hs   = wvalid & wready;
  wire       ar_hs  = arvalid & arready;
  wire       wr_go  = ~awready & ~wready & ~bvalid;
  wire [4:0] wr_dec = ctc_decode(wr_addr);
  wire [4:0] rd_dec = ctc_decode(araddr);
  wire       wr_hit = wr_go & wr_be;
  wire       cw_wr  = wr_hit & wr_dec[3];
  wire [1:0] sc_fld = wr_byte[7:6];
  wire       rb_cmd = cw_wr & (sc_fld == ctc_pkg::SC_MULTI_CHANNEL_CAPTURE_COMMAND);
  wire ctc_pkg::ctc_cw_t new_cw = ctc_pkg::ctc_cw_t'(wr_byte[5:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= ctc_pkg::RESP_OKAY;
      wr_addr <= '0;
      wr_byte <= 8'h00;
      wr_be   <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (w_hs) begin
        wready  <= 1'b0;
        wr_byte <= wdata[7:0];
        wr_be   <= wstrb[0];
      end
      if (wr_go) begin
        bvalid  <= 1'b1;
        bresp   <= (|wr_dec) ? ctc_pkg::RESP_OKAY : ctc_pkg::RESP_DECERR;
        awready <= 1'b1;
        wready  <= 1'b1;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ctc_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= (|rd_dec) ? ctc_pkg::RESP_OKAY : ctc_pkg::RESP_DECERR;
      rdata   <= rd_dec[4] ? {16'h0000, clk_sel} : {24'h000000, rd_byte};
    end else if (rvalid & rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Counting clock: external pin edge or divided system clock
  logic [7:0] div_cnt;
  logic       ext_q;
  logic       tick;
  logic       wstrb_hi;
  logic [7:0] wr_hi_byte;
  wire        src_ext  = clk_sel[0];
  wire [7:0]  prescale = clk_sel[15:8];
  wire        div_hit  = (div_cnt == prescale);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sel <= {ctc_pkg::PRESCALE_RST, 8'h00};
      div_cnt <= 8'h00;
      ext_q   <= 1'b0;
      tick    <= 1'b0;
    end else begin
      if (wr_hit & wr_dec[4]) begin
        clk_sel <= {clk_sel[15:8], wr_byte};
      end
      if (wr_go & wstrb_hi & wr_dec[4]) begin
        clk_sel[15:8] <= wr_hi_byte;
      end
      ext_q   <= external_count_clock;
      div_cnt <= div_hit ? 8'h00 : div_cnt + 8'h01;
      tick    <= src_ext ? (external_count_clock & ~ext_q) : div_hit;
    end
  end

  // Upper lane of the clock select register is captured alongside the low one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstrb_hi   <= 1'b0;
      wr_hi_byte <= 8'h00;
    end else if (w_hs) begin
      wstrb_hi   <= wstrb[1];
      wr_hi_byte <= wdata[15:8];
    end
  end

  // Channel state
  ctc_pkg::ctc_cw_t cw [0:2];
  logic [15:0] ce [0:2];
  logic [15:0] cr [0:2];
  logic [15:0] ol [0:2];
  logic [7:0]  st [0:2];
  logic [7:0]  rd_val [0:2];
  logic [2:0]  ol_hold, st_hold, null_cnt, pend, run;
  logic [2:0]  wr_hi, rd_hi, ch_out, gate_q, trig;
  logic [2:0]  cw_prog, latch_cmd, rb_cnt, rb_st, dat_wr, dat_rd;

  assign channel_output_pin = ch_out;

  always_comb begin
    rd_byte = 8'h00;
    for (int k = 0; k < ctc_pkg::NUM_CH; k++) begin
      if (rd_dec[k]) begin
        rd_byte = rd_val[k];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ctc_pkg::NUM_CH; gi++) begin : g_ch
      wire sel_me  = cw_wr & (sc_fld == 2'(gi));
      wire rb_me   = rb_cmd & wr_byte[ctc_pkg::RB_SEL_LO + gi];
      assign cw_prog[gi]   = sel_me & (new_cw.af != ctc_pkg::AF_LATCH);
      assign latch_cmd[gi] = sel_me & (new_cw.af == ctc_pkg::AF_LATCH);
      assign rb_cnt[gi]    = rb_me & ~wr_byte[ctc_pkg::RB_COUNT_N];
      assign rb_st[gi]     = rb_me & ~wr_byte[ctc_pkg::RB_STATUS_N];
      assign dat_wr[gi]    = wr_hit & wr_dec[gi];
      assign dat_rd[gi]    = ar_hs & rd_dec[gi];

      wire ctc_pkg::ctc_mode_t md = cw[gi].mode;
      wire hw_md   = (md == ctc_pkg::MD_ONESHOT) | (md == ctc_pkg::MD_HW_STROBE);
      wire gate    = channel_gate_pin[gi];
      wire hi_pick = (cw[gi].af == ctc_pkg::AF_HIGH) |
                     ((cw[gi].af == ctc_pkg::AF_BOTH) & rd_hi[gi]);
      wire last_rd = (cw[gi].af != ctc_pkg::AF_BOTH) | rd_hi[gi];
      wire [15:0] dec1    = ctc_dec1(ce[gi], cw[gi].bcd);
      wire [15:0] next_ce = (md == ctc_pkg::MD_SQUARE) ? ctc_dec1(dec1, cw[gi].bcd) : dec1;
      wire        do_load = hw_md ? (trig[gi] & run[gi]) : pend[gi];
      wire        cnt_en  = run[gi] & (gate | hw_md);
      wire        at_one  = (ce[gi] == ctc_pkg::CNT_ONE);
      // A read that frees the latch and a new latch in one cycle: the new latch wins
      wire        ol_free = ~ol_hold[gi] | (dat_rd[gi] & ~st_hold[gi] & last_rd);

      assign rd_val[gi] = st_hold[gi] ? st[gi] : (hi_pick ? ol[gi][15:8] : ol[gi][7:0]);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cw[gi]       <= '0;
          ce[gi]       <= ctc_pkg::CNT_ZERO;
          cr[gi]       <= ctc_pkg::CNT_ZERO;
          ol[gi]       <= ctc_pkg::CNT_ZERO;
          st[gi]       <= 8'h00;
          ol_hold[gi]  <= 1'b0;
          st_hold[gi]  <= 1'b0;
          null_cnt[gi] <= 1'b0;
          pend[gi]     <= 1'b0;
          run[gi]      <= 1'b0;
          wr_hi[gi]    <= 1'b0;
          rd_hi[gi]    <= 1'b0;
          ch_out[gi]   <= 1'b0;
          gate_q[gi]   <= 1'b1; // Idle gate level, so release fakes no trigger
          trig[gi]     <= 1'b0;
        end else begin
          gate_q[gi] <= gate;
          // Edge trigger is kept until the next count tick samples it
          trig[gi] <= (gate & ~gate_q[gi]) | (trig[gi] & ~tick);
          if (ol_free) begin
            ol[gi] <= ce[gi];
          end
          if (cw_prog[gi]) begin
            cw[gi]       <= new_cw;
            null_cnt[gi] <= 1'b1;
            pend[gi]     <= 1'b0;
            run[gi]      <= 1'b0;
            wr_hi[gi]    <= 1'b0;
            rd_hi[gi]    <= 1'b0;
            ol_hold[gi]  <= 1'b0;
            st_hold[gi]  <= 1'b0;
            ch_out[gi]   <= (new_cw.mode != ctc_pkg::MD_TC_INT);
          end else begin
            if (dat_rd[gi]) begin
              if (st_hold[gi]) begin
                st_hold[gi] <= 1'b0;
              end else if (last_rd) begin
                rd_hi[gi]   <= 1'b0;
                ol_hold[gi] <= 1'b0;
              end else begin
                rd_hi[gi] <= 1'b1;
              end
            end
            if ((latch_cmd[gi] | rb_cnt[gi]) & ol_free) begin
              ol_hold[gi] <= 1'b1;
            end
            if (rb_st[gi] & (~st_hold[gi] | dat_rd[gi])) begin
              st_hold[gi] <= 1'b1;
              st[gi]      <= {ch_out[gi], null_cnt[gi], cw[gi]};
            end
            if (dat_wr[gi]) begin
              case (cw[gi].af)
                ctc_pkg::AF_LOW: begin
                  cr[gi] <= {8'h00, wr_byte};
                end
                ctc_pkg::AF_HIGH: begin
                  cr[gi] <= {wr_byte, 8'h00};
                end
                default: begin
                  if (!wr_hi[gi]) begin
                    cr[gi][7:0] <= wr_byte;
                  end else begin
                    cr[gi][15:8] <= wr_byte;
                  end
                  wr_hi[gi] <= ~wr_hi[gi];
                end
              endcase
              if ((cw[gi].af != ctc_pkg::AF_BOTH) | wr_hi[gi]) begin
                null_cnt[gi] <= 1'b1;
                pend[gi]     <= ~hw_md;
                run[gi]      <= run[gi] | hw_md;
              end
            end else if (tick) begin
              if (do_load) begin
                ce[gi]       <= cr[gi];
                null_cnt[gi] <= 1'b0;
                pend[gi]     <= 1'b0;
                run[gi]      <= 1'b1;
                ch_out[gi]   <= (md != ctc_pkg::MD_TC_INT) & (md != ctc_pkg::MD_ONESHOT);
              end else if (cnt_en) begin
                ce[gi] <= next_ce;
                case (md)
                  ctc_pkg::MD_TC_INT, ctc_pkg::MD_ONESHOT: begin
                    if (at_one) begin
                      ch_out[gi] <= 1'b1;
                    end
                  end
                  ctc_pkg::MD_RATE: begin
                    ch_out[gi] <= (ce[gi] != ctc_pkg::CNT_TWO);
                    if (at_one) begin
                      ce[gi]       <= cr[gi];
                      null_cnt[gi] <= 1'b0;
                    end
                  end
                  ctc_pkg::MD_SQUARE: begin
                    if (ce[gi] <= ctc_pkg::CNT_TWO) begin
                      ce[gi]       <= cr[gi];
                      null_cnt[gi] <= 1'b0;
                      ch_out[gi]   <= ~ch_out[gi];
                    end
                  end
                  default: begin
                    ch_out[gi] <= ~at_one;
                    if (ce[gi] == ctc_pkg::CNT_ZERO) begin
                      run[gi] <= 1'b0;
                    end
                  end
                endcase
              end else if ((md == ctc_pkg::MD_RATE) | (md == ctc_pkg::MD_SQUARE)) begin
                ch_out[gi] <= 1'b1;
              end
            end
          end
        end
      end

      a_cw_cancels: assert property (@(posedge aclk) disable iff (!aresetn)
        cw_prog[gi] |=> !ol_hold[gi] && !st_hold[gi] && null_cnt[gi] && !run[gi])
        else $error("control word write did not reset channel");

      a_latch_freezes: assert property (@(posedge aclk) disable iff (!aresetn)
        latch_cmd[gi] && !ol_hold[gi] && !dat_rd[gi]
        |=> ol_hold[gi] && ol[gi] == $past(ce[gi]))
        else $error("snapshot did not capture counter");

      a_latch_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        ol_hold[gi] && !dat_rd[gi] && !cw_prog[gi] |=> $stable(ol[gi]) && ol_hold[gi])
        else $error("frozen latch changed before read");

      a_single_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        dat_wr[gi] && cw[gi].af == ctc_pkg::AF_LOW |=> cr[gi][15:8] == 8'h00)
        else $error("unused byte not forced to zero");

      a_byte_order: assert property (@(posedge aclk) disable iff (!aresetn)
        dat_wr[gi] && cw[gi].af == ctc_pkg::AF_BOTH && !wr_hi[gi]
        |=> wr_hi[gi] && !null_cnt[gi] == !$past(null_cnt[gi]))
        else $error("low byte did not advance pointer");

      a_status_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        rb_st[gi] && !st_hold[gi]
        |=> st[gi] == {$past(ch_out[gi]), $past(null_cnt[gi]), $past(cw[gi])})
        else $error("status byte fields wrong");

      a_status_first: assert property (@(posedge aclk) disable iff (!aresetn)
        dat_rd[gi] && st_hold[gi] |=> rvalid && rdata[7:0] == $past(st[gi]) ##0 !st_hold[gi])
        else $error("status not returned first");

      a_load_moves: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && pend[gi] && !dat_wr[gi] && !cw_prog[gi]
        |=> ce[gi] == $past(cr[gi]) && !null_cnt[gi])
        else $error("holding value not moved to counter");

      c_latch_read: cover property (@(posedge aclk) disable iff (!aresetn)
        latch_cmd[gi] ##[1:40] dat_rd[gi] && ol_hold[gi]);
    end
  endgenerate

  a_cw_write_only: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && rd_dec[3] |=> rvalid && rdata == 32'h0000_0000 && rresp == ctc_pkg::RESP_OKAY)
    else $error("control word port read not zero");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> bvalid && awready && wready)
    else $error("write response missing");

  c_multi_channel_capture_command_both: cover property (@(posedge aclk) disable iff (!aresetn)
    rb_cmd && !wr_byte[ctc_pkg::RB_COUNT_N] && !wr_byte[ctc_pkg::RB_STATUS_N]);
  c_square_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
    cw[0].mode == ctc_pkg::MD_SQUARE && $changed(ch_out[0]));
  c_two_byte: cover property (@(posedge aclk) disable iff (!aresetn)
    dat_wr[1] && wr_hi[1]);

endmodule
`default_nettype wire

// [tb/ctc_pins.sv]
`default_nettype none
module ctc_pins (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Requests from the bench
  input  wire logic       pulse,
  input  wire logic [2:0] gate_set,
  // Pins toward the block
  output logic            ext_clk,
  output logic [2:0]      gate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  // Clock stands still between requested pulses, so every tick is accounted for
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase   <= 2'h0;
      ext_clk <= 1'b0;
    end else if (pulse && phase == 2'h0) begin
      phase   <= 2'h3;
      ext_clk <= 1'b1;
    end else if (phase != 2'h0) begin
      phase   <= phase - 2'h1;
      ext_clk <= (phase == 2'h3);
    end
  end
  always_ff @(posedge aclk) begin
    gate <= gate_set;
  end
endmodule
`default_nettype wire

// [tb/three_channel_counter_timer_test.sv]
`default_nettype none
module three_channel_counter_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] P0 = ctc_pkg::OFS_CNT[0];
  localparam logic [7:0] P1 = ctc_pkg::OFS_CNT[1];
  localparam logic [7:0] P2 = ctc_pkg::OFS_CNT[2];
  localparam logic [7:0] CW = ctc_pkg::OFS_CW;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ext_clk, pulse;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  gate, gate_set, outs;
  int          n_errors, compares;
  ctc_top u_ctc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .external_count_clock(ext_clk), .channel_gate_pin(gate), .channel_output_pin(outs));
  ctc_pins u_ctc_pins (.aclk(aclk), .aresetn(aresetn), .pulse(pulse), .gate_set(gate_set),
    .ext_clk(ext_clk), .gate(gate));
  always #12.5 aclk = ~aclk;
  task automatic close_out();
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, {24'h0, d}, r);
    check({30'h0, r}, {30'h0, ctc_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    check({30'h0, r}, {30'h0, ctc_pkg::RESP_OKAY});
    check(d & {24'h0, mask}, {24'h0, exp});
  endtask
  // One external tick, then enough aclk cycles for it to cross and land
  task automatic tick();
    @(posedge aclk);
    pulse <= 1'b1;
    @(posedge aclk);
    pulse <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c;
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'h0; pulse = 1'b0; gate_set = 3'h7; n_errors = 0; compares = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wr(ctc_pkg::OFS_CLK, 8'h01);
    rd(CW, 8'hff, 8'h00);
    axw(8'h20, 32'h0, r);
    check({30'h0, r}, {30'h0, ctc_pkg::RESP_DECERR});
    axr(8'h20, d, r);
    check({30'h0, r}, {30'h0, ctc_pkg::RESP_DECERR});
    // Channel 0: two-byte binary, mode 0
    wr(CW, 8'h30);
    wr(CW, 8'he2);
    rd(P0, 8'hff, 8'h70);
    wr(P0, 8'h34);
    wr(P0, 8'h12);
    wr(CW, 8'he2);
    rd(P0, 8'hff, 8'h70);
    tick();
    wr(CW, 8'h00);
    rd(P0, 8'hff, 8'h34);
    rd(P0, 8'hff, 8'h12);
    tick();
    wr(CW, 8'h00);
    tick();
    wr(CW, 8'h00);
    rd(P0, 8'hff, 8'h33);
    rd(P0, 8'hff, 8'h12);
    wr(CW, 8'hc2);
    rd(P0, 8'hff, 8'h30);
    rd(P0, 8'hff, 8'h32);
    rd(P0, 8'hff, 8'h12);
    // Channel 1 two-byte count split by channel 2 programming
    wr(CW, 8'h70);
    wr(P1, 8'h78);
    wr(CW, 8'h90);
    wr(P2, 8'h56);
    wr(P1, 8'h9a);
    tick();
    wr(CW, 8'h40);
    wr(CW, 8'h80);
    rd(P1, 8'hff, 8'h78);
    rd(P1, 8'hff, 8'h9a);
    rd(P2, 8'hff, 8'h56);
    gate_set <= 3'h5;
    tick();
    wr(CW, 8'h40);
    rd(P1, 8'hff, 8'h78);
    rd(P1, 8'hff, 8'h9a);
    gate_set <= 3'h7;
    // Every mode code, alternating binary and decimal
    for (int m = 0; m < 6; m++) begin
      c = 8'hb0 | 8'(m << 1) | 8'(m & 1);
      wr(CW, c);
      check({31'h0, outs[2]}, {31'h0, 1'(m != 0)});
      wr(CW, 8'he8);
      rd(P2, 8'h7f, 8'h40 | (c & 8'h3f));
    end
    // Decimal count: 1000 less one is 0999
    wr(CW, 8'hb1);
    wr(P2, 8'h00);
    wr(P2, 8'h10);
    tick();
    tick();
    wr(CW, 8'h80);
    rd(P2, 8'hff, 8'h99);
    rd(P2, 8'hff, 8'h09);
    wr(P2, 8'h05);
    wr(P2, 8'h00);
    wr(CW, 8'he8);
    rd(P2, 8'h7f, 8'h71);
    // Square wave on channel 0: count 4 toggles the output every two ticks
    wr(CW, 8'h16);
    check({31'h0, outs[0]}, 32'h1);
    wr(P0, 8'h04);
    repeat (3) tick();
    check({31'h0, outs[0]}, 32'h0);
    repeat (2) tick();
    check({31'h0, outs[0]}, 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
